// *** verilog/refgen_regs.vh ***
// register offsets, field positions, reset values for the reference clock
`ifndef REFGEN_REGS_VH
`define REFGEN_REGS_VH

// ***********************************************************
// register offsets (word index on the register port)
// ***********************************************************
`define REFGEN_ADDR_W 2
`define REFGEN_CONTROL_LOW_ADDR 2'h0
`define REFGEN_CONTROL_HIGH_ADDR 2'h1
`define REFGEN_TRIM_ADDR 2'h2

// ***********************************************************
// field positions
// ***********************************************************
`define REFGEN_ENABLE_BIT 15
`define REFGEN_PIN_OE_BIT 12
`define REFGEN_SLEEP_RUN_BIT 11
`define REFGEN_SWITCH_BIT 9
`define REFGEN_ACTIVE_BIT 8
`define REFGEN_SELECT_MSB 3
`define REFGEN_SELECT_LSB 0
`define REFGEN_DIVIDER_MSB 14
`define REFGEN_DIVIDER_LSB 0
`define REFGEN_TRIM_MSB 15
`define REFGEN_TRIM_LSB 7

// ***********************************************************
// reset values
// ***********************************************************
`define REFGEN_SELECT_RESET 4'h0
`define REFGEN_DIVIDER_RESET 15'h0000
`define REFGEN_TRIM_RESET 9'h000
`define REFGEN_SELECT_SYSCLK 4'h0

`endif

// *** verilog/sync_two_flop.v ***
// two flip-flop level synchroniser, any width
`timescale 1ns/10ps
module sync_two_flop #(
  parameter W = 1
) (
  input wire mclk,
  input wire rst_n,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // first stage feeds only the second stage
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // sync_two_flop

// *** verilog/frac_divider.v ***
// half-period counter with fractional trim accumulator
`timescale 1ns/10ps
module frac_divider #(
  parameter DW = 15,
  parameter TW = 9
) (
  input wire mclk,
  input wire rst_n,
  input wire tick,
  input wire run,
  input wire [DW-1:0] div_n,
  input wire [TW-1:0] trim,
  output wire level,
  output wire fall
);
  reg [DW:0] cnt_q;
  reg [TW-1:0] acc_q;
  reg extra_q;
  reg level_q;
  wire [DW:0] half_len;
  wire [DW:0] cnt_inc;
  wire terminal;
  wire [TW:0] acc_sum;

  // a half period lasts div_n source edges, plus one when trim carries
  assign half_len = {1'b0, div_n} + {{DW{1'b0}}, extra_q};
  assign cnt_inc = cnt_q + {{DW{1'b0}}, 1'b1};
  assign terminal = (cnt_inc >= half_len);
  assign acc_sum = {1'b0, acc_q} + {1'b0, trim};
  assign fall = tick & terminal & level_q & run;
  assign level = level_q;

  // keeps counting while running, or to finish a high phase on stop
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= {(DW+1){1'b0}};
      acc_q <= {TW{1'b0}};
      extra_q <= 1'b0;
      level_q <= 1'b0;
    end
    else if (!run && !level_q)
    begin
      cnt_q <= {(DW+1){1'b0}};
      acc_q <= {TW{1'b0}};
      extra_q <= 1'b0;
    end
    else if (tick)
    begin
      if (terminal)
      begin
        cnt_q <= {(DW+1){1'b0}};
        level_q <= ~level_q;
        acc_q <= acc_sum[TW-1:0]; // fractional part carried on [R4]
        extra_q <= acc_sum[TW];
      end
      else
      begin
        cnt_q <= cnt_inc;
      end
    end
  end
endmodule // frac_divider

// *** verilog/refgen_top.v ***
// reference clock output generator with register port
//
// How it works
// R1: enable bit 15 of control low drives the generated clock out.
// R2: four-bit select in control low bits 3:0 picks the source.
// R3: fifteen-bit divider in control high 14:0, ratios 1:1 to 1:65,534.
// R4: nine-bit trim in trim register 15:7 adds a fractional part.
// R5: switch flag, control low bit 9, stays set while values switch in.
// R6: software checks the switch flag clear before writing divider or trim.
// R7: software sets the switch flag and polls it clear before use.
// R8: output runs in sleep only with sleep-run bit 11 and sleep-capable source.
// R9: select zero takes the system clock, following its switches.
// R10: separate pin output enable gates the clock onto the pin.
// R11: active status bit 8 set while active, cleared after disable.
// R12: software leaves source, trim, divider alone while active shows set.
// R13: software clears enable only after active status has read one.
// R14: fixed half oscillator clock out where the oscillator mode allows it.
// R15: new divider and trim take effect only at an output clock boundary; the code also loads them on the next edge while active status is clear.
// R16: reset clears all control, output off, status and flag clear.
`timescale 1ns/10ps
`include "refgen_regs.vh"
module refgen_top #(
  parameter DW = 15,
  parameter TW = 9,
  parameter NSRC = 15
) (
  input wire mclk,
  input wire rst_n,
  input wire [`REFGEN_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [15:0] reg_rdata,
  input wire [NSRC-1:0] src_clk_in,
  input wire [NSRC:0] src_runs_in_sleep,
  input wire sleep_mode,
  input wire half_osc_allowed,
  output wire reference_clock_pin,
  output wire reference_clock_pin_oe,
  output wire half_osc_clock_out,
  output wire generator_active_out
);

  // ***********************************************************
  // software control state
  // ***********************************************************
  reg refgen_enable_q;
  reg pin_output_enable_q;
  reg run_in_sleep_q;
  reg [3:0] refgen_source_select_q;
  reg [DW-1:0] refgen_integer_divider_q;
  reg [TW-1:0] refgen_fraction_trim_q;
  reg divider_switch_flag_q;
  reg generator_active_status_q;
  reg [15:0] rdata_q;

  // values the divider really uses, loaded at a boundary or while inactive
  reg [DW-1:0] applied_div_q;
  reg [TW-1:0] applied_trim_q;

  // ***********************************************************
  // pins and foreign clocks brought into the mclk domain
  // ***********************************************************
  // bit positions of each group inside the synchroniser bus
  localparam SLEEP_LO = NSRC;
  localparam SLEEP_HI = NSRC + NSRC;
  localparam SLEEP_BIT = NSRC + NSRC + 1;
  localparam HALF_BIT = NSRC + NSRC + 2;
  localparam SW = NSRC + NSRC + 3;
  wire [SW-1:0] sync_bus;
  wire [NSRC-1:0] src_sync;
  wire [NSRC:0] sleep_ok_sync;
  wire sleep_sync;
  wire half_allow_sync;

  // one synchroniser for every foreign input, first stage never read
  sync_two_flop #(
    .W(SW)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in({half_osc_allowed, sleep_mode, src_runs_in_sleep,
      src_clk_in}),
    .sync_out(sync_bus)
  );

  // split the synchronised bus back into its groups
  assign src_sync = sync_bus[NSRC-1:0];
  assign sleep_ok_sync = sync_bus[SLEEP_HI:SLEEP_LO];
  assign sleep_sync = sync_bus[SLEEP_BIT];
  assign half_allow_sync = sync_bus[HALF_BIT];

  // ***********************************************************
  // source selection and edge ticks
  // ***********************************************************
  // tick and level of the chosen source
  reg [NSRC-1:0] src_prev_q;
  reg sys_toggle_q;
  reg src_tick;
  reg src_level;

  // edge detect reads only the settled second-stage copy
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      src_prev_q <= {NSRC{1'b0}};
      sys_toggle_q <= 1'b0;
    end
    else
    begin
      src_prev_q <= src_sync;
      sys_toggle_q <= ~sys_toggle_q;
    end
  end

  // system clock source ticks every cycle; others on a rising edge
  always @*
  begin
    src_tick = 1'b0;
    src_level = 1'b0;
    if (refgen_source_select_q == `REFGEN_SELECT_SYSCLK)
    begin
      src_tick = 1'b1; // [R9]
      src_level = sys_toggle_q;
    end
    else if ({28'h0000000, refgen_source_select_q} <= NSRC)
    begin
      src_tick = src_sync[refgen_source_select_q - 4'h1] &
        ~src_prev_q[refgen_source_select_q - 4'h1]; // [R2]
      src_level = src_sync[refgen_source_select_q - 4'h1];
    end
  end

  // ***********************************************************
  // run decision, divider and output gating
  // ***********************************************************
  wire sleep_blocks;
  wire gen_run;
  wire div_level;
  wire div_fall;
  wire gen_level;
  wire bypass;

  // in sleep the clock survives only if asked to and its source runs
  assign sleep_blocks = sleep_sync &
    ~(run_in_sleep_q & sleep_ok_sync[refgen_source_select_q]); // [R8]
  assign gen_run = refgen_enable_q & ~sleep_blocks; // [R1]
  assign bypass = (applied_div_q == {DW{1'b0}});

  // divider runs on the applied copies, never on the live fields
  frac_divider #(
    .DW(DW),
    .TW(TW)
  ) u_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(src_tick),
    .run(gen_run),
    .div_n(applied_div_q), // [R3]
    .trim(applied_trim_q), // [R4]
    .level(div_level),
    .fall(div_fall)
  );

  // zero divider passes the source straight through; no trim then
  assign gen_level = bypass ? (src_level & gen_run) : div_level;

  // pin drive registers
  reg refclk_q;
  reg refclk_oe_q;

  // registered pin drive; low whenever gated so no half pulse escapes
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refclk_q <= 1'b0;
      refclk_oe_q <= 1'b0;
    end
    else
    begin
      refclk_q <= gen_level & pin_output_enable_q; // [R10] [R1]
      refclk_oe_q <= pin_output_enable_q & refgen_enable_q; // [R10]
    end
  end

  // ***********************************************************
  // boundary for switching divider values
  // ***********************************************************
  wire at_boundary;
  wire apply_now;

  // bypass has no half-period, a low source level is the boundary
  assign at_boundary = bypass ? ~gen_level : div_fall;
  assign apply_now = divider_switch_flag_q &
    (at_boundary | ~generator_active_status_q); // [R15]

  // ***********************************************************
  // register writes and hardware flag updates
  // ***********************************************************
  wire wr_low;
  wire wr_high;
  wire wr_trim;
  wire sw_set;

  // one write decode per register
  assign wr_low = reg_wr & (reg_addr == `REFGEN_CONTROL_LOW_ADDR);
  assign wr_high = reg_wr & (reg_addr == `REFGEN_CONTROL_HIGH_ADDR);
  assign wr_trim = reg_wr & (reg_addr == `REFGEN_TRIM_ADDR);
  assign sw_set = wr_low & reg_wdata[`REFGEN_SWITCH_BIT];

  // software control fields, all cleared by reset
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refgen_enable_q <= 1'b0; // [R16]
      pin_output_enable_q <= 1'b0;
      run_in_sleep_q <= 1'b0;
      refgen_source_select_q <= `REFGEN_SELECT_RESET;
      refgen_integer_divider_q <= `REFGEN_DIVIDER_RESET;
      refgen_fraction_trim_q <= `REFGEN_TRIM_RESET;
    end
    else
    begin
      if (wr_low)
      begin
        refgen_enable_q <= reg_wdata[`REFGEN_ENABLE_BIT];
        pin_output_enable_q <= reg_wdata[`REFGEN_PIN_OE_BIT];
        run_in_sleep_q <= reg_wdata[`REFGEN_SLEEP_RUN_BIT];
        refgen_source_select_q <=
          reg_wdata[`REFGEN_SELECT_MSB:`REFGEN_SELECT_LSB];
      end
      if (wr_high)
        refgen_integer_divider_q <=
          reg_wdata[`REFGEN_DIVIDER_MSB:`REFGEN_DIVIDER_LSB];
      if (wr_trim)
        refgen_fraction_trim_q <=
          reg_wdata[`REFGEN_TRIM_MSB:`REFGEN_TRIM_LSB];
    end
  end

  // switch flag: software sets, hardware clears; a set beats the clear
  // a switch while inactive lands on the next edge, nothing to glitch
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divider_switch_flag_q <= 1'b0; // [R16]
      applied_div_q <= `REFGEN_DIVIDER_RESET;
      applied_trim_q <= `REFGEN_TRIM_RESET;
    end
    else
    begin
      if (apply_now)
      begin
        applied_div_q <= refgen_integer_divider_q; // [R15]
        applied_trim_q <= refgen_fraction_trim_q;
      end
      if (sw_set)
        divider_switch_flag_q <= 1'b1; // [R5]
      else if (apply_now)
        divider_switch_flag_q <= 1'b0; // [R5] [R15]
    end
  end

  // active follows enable, drops only after the output settles low
  // software waits on this before retuning, so it must not drop early
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      generator_active_status_q <= 1'b0; // [R16]
    else if (refgen_enable_q)
      generator_active_status_q <= 1'b1; // [R11]
    else if (!gen_level)
      generator_active_status_q <= 1'b0; // [R11]
  end

  // ***********************************************************
  // register reads, data stand one cycle after the strobe
  // ***********************************************************
  reg [15:0] rd_mux;

  // read multiplexer, reserved bits stay zero
  always @*
  begin
    rd_mux = 16'h0000;
    case (reg_addr)
      `REFGEN_CONTROL_LOW_ADDR:
      begin
        rd_mux[`REFGEN_ENABLE_BIT] = refgen_enable_q;
        rd_mux[`REFGEN_PIN_OE_BIT] = pin_output_enable_q;
        rd_mux[`REFGEN_SLEEP_RUN_BIT] = run_in_sleep_q;
        rd_mux[`REFGEN_SWITCH_BIT] = divider_switch_flag_q;
        rd_mux[`REFGEN_ACTIVE_BIT] = generator_active_status_q;
        rd_mux[`REFGEN_SELECT_MSB:`REFGEN_SELECT_LSB] =
          refgen_source_select_q;
      end
      `REFGEN_CONTROL_HIGH_ADDR:
        rd_mux[`REFGEN_DIVIDER_MSB:`REFGEN_DIVIDER_LSB] =
          refgen_integer_divider_q;
      `REFGEN_TRIM_ADDR:
        rd_mux[`REFGEN_TRIM_MSB:`REFGEN_TRIM_LSB] = refgen_fraction_trim_q;
      default:
        rd_mux = 16'h0000; // unmapped reads as zero
    endcase
  end

  // read data valid only in the cycle after the strobe, zero otherwise
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 16'h0000;
    else if (reg_rd)
      rdata_q <= rd_mux;
    else
      rdata_q <= 16'h0000;
  end

  // ***********************************************************
  // fixed half oscillator clock output
  // ***********************************************************
  reg half_osc_q;

  // mclk stands in for the oscillator; held low in modes without it
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      half_osc_q <= 1'b0;
    else if (half_allow_sync)
      half_osc_q <= ~half_osc_q; // [R14]
    else
      half_osc_q <= 1'b0;
  end

  // ***********************************************************
  // outputs, all from flip-flops
  // ***********************************************************
  assign reg_rdata = rdata_q;
  assign reference_clock_pin = refclk_q;
  assign reference_clock_pin_oe = refclk_oe_q;
  assign half_osc_clock_out = half_osc_q;
  assign generator_active_out = generator_active_status_q;
endmodule // refgen_top

// *** verif/refgen_assertions.sv ***
// port assertions for the reference clock generator
`timescale 1ns/10ps
module refgen_checker (
  input wire mclk,
  input wire rst_n,
  input wire [1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire half_osc_allowed,
  input wire reference_clock_pin_oe,
  input wire half_osc_clock_out,
  input wire generator_active_out
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // write to control low, decoded once
  wire wr_ctl = reg_wr && reg_addr == 2'h0;

  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  unmapped_read_a: assert property (
    $past(reg_rd) && $past(reg_addr) == 2'h3 |-> reg_rdata == 16'h0000)
    else $error("unmapped slot read not zero");
  reserved_bits_a: assert property (
    $past(reg_rd) && $past(reg_addr) == 2'h0 |->
    (reg_rdata & 16'h64f0) == 16'h0000)
    else $error("reserved control bits not zero");
  trim_low_a: assert property (
    $past(reg_rd) && $past(reg_addr) == 2'h2 |-> reg_rdata[6:0] == 7'h00)
    else $error("trim low bits not zero");
  enable_oe_a: assert property (
    wr_ctl && reg_wdata[15] && reg_wdata[12] |->
    ##[1:3] reference_clock_pin_oe)
    else $error("pin not enabled");
  oe_off_a: assert property (
    wr_ctl && !(reg_wdata[15] && reg_wdata[12]) |->
    ##[1:3] !reference_clock_pin_oe)
    else $error("pin left enabled");
  active_on_a: assert property (
    wr_ctl && reg_wdata[15] |-> ##[1:3] generator_active_out)
    else $error("active status not set");
  active_off_a: assert property (
    wr_ctl && !reg_wdata[15] |-> ##[1:300] !generator_active_out)
    else $error("active status not cleared");
  half_run_a: assert property (
    half_osc_allowed [*4] |=> half_osc_clock_out != $past(half_osc_clock_out))
    else $error("half clock not toggling");
  half_off_a: assert property (
    !half_osc_allowed [*4] |=> !half_osc_clock_out)
    else $error("half clock running while barred");
endmodule // refgen_checker

bind refgen_top refgen_checker chk_i (.mclk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .half_osc_allowed, .reference_clock_pin_oe,
  .half_osc_clock_out, .generator_active_out);

// *** verif/ref_clock_consumer.sv ***
// external consumer that times the reference clock seen on the pad
`timescale 1ns/10ps
module ref_clock_consumer (
  input wire mclk,
  input wire rst_n,
  input wire pin,
  input wire pin_oe,
  output reg [15:0] period_q,
  output reg [15:0] edges_q
);
  reg [15:0] count_q;
  reg last_q;
  // pad has a pull-down, so an undriven pin reads low
  wire pad = pin_oe & pin;

  // period in system cycles between rising edges, and edge count
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      period_q <= 16'h0000;
      edges_q <= 16'h0000;
      count_q <= 16'h0000;
      last_q <= 1'b0;
    end
    else
    begin
      last_q <= pad;
      count_q <= count_q + 16'h0001;
      if (pad && !last_q)
      begin
        period_q <= count_q;
        edges_q <= edges_q + 16'h0001;
        count_q <= 16'h0001;
      end
    end
  end
endmodule // ref_clock_consumer

// *** verif/tb_top.sv ***
// self-checking bench for the reference clock generator
`timescale 1ns/10ps
module tb_top;
  reg mclk = 1'b0;
  reg rst_n = 1'b0;
  reg [1:0] reg_addr = 2'h0;
  reg [15:0] reg_wdata = 16'h0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [15:0] src_runs_in_sleep = 16'h0000;
  reg sleep_mode = 1'b0;
  reg half_osc_allowed = 1'b0;
  reg [1:0] src_count_q = 2'h0;
  reg [15:0] rd_val;
  reg [15:0] e0;
  integer miscompares = 0;
  integer comparisons = 0;
  integer i;
  wire [15:0] reg_rdata;
  wire [15:0] period;
  wire [15:0] edges;
  wire pin;
  wire pin_oe;
  wire half_out;
  wire active;
  // source 1 runs at a quarter of the system clock, others idle
  wire [14:0] src_clk_in = {14'h0000, src_count_q[1]};

  // ****************
  // clock and sources
  // ****************
  always #5 mclk = ~mclk;
  always @(posedge mclk) src_count_q <= src_count_q + 2'h1;

  refgen_top dut (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .src_clk_in, .src_runs_in_sleep, .sleep_mode,
    .half_osc_allowed, .reference_clock_pin(pin),
    .reference_clock_pin_oe(pin_oe), .half_osc_clock_out(half_out),
    .generator_active_out(active));
  ref_clock_consumer peer (.mclk, .rst_n, .pin(pin), .pin_oe(pin_oe),
    .period_q(period), .edges_q(edges));

  // ****************
  // tasks
  // ****************
  task chk(input [15:0] got, input [15:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task wr(input [1:0] a, input [15:0] d);
  begin
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  end
  endtask
  // data stand in the cycle after the strobe only
  task rd(input [1:0] a, output [15:0] d);
  begin
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  end
  endtask
  task poll(input [15:0] mask, input [15:0] exp);
    integer n;
  begin
    n = 0;
    rd(2'h0, rd_val);
    while ((rd_val & mask) !== exp && n < 60)
    begin
      rd(2'h0, rd_val);
      n = n + 1;
    end
    chk(rd_val & mask, exp);
  end
  endtask
  // values change only while stopped, so no runt pulse can escape
  task retune(input [15:0] trim, input [15:0] ctl);
  begin
    wr(2'h0, 16'h1000);
    poll(16'h0100, 16'h0000);
    poll(16'h0200, 16'h0000);
    wr(2'h2, trim);
    wr(2'h0, ctl);
    poll(16'h0200, 16'h0000);
  end
  endtask
  task wrap_up;
  begin
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask

  // ****************
  // tests
  // ****************
  initial
  begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    wr(2'h3, 16'hffff);
    for (i = 0; i < 4; i = i + 1)
    begin
      rd(i[1:0], rd_val);
      chk(rd_val, 16'h0000);
    end
    chk({13'h0000, pin_oe, pin, active}, 16'h0000);
    // system clock source, divider three, divide by six
    wr(2'h1, 16'h0003);
    retune(16'h0000, 16'h9200);
    rd(2'h0, rd_val);
    chk(rd_val, 16'h9100);
    rd(2'h1, rd_val);
    chk(rd_val, 16'h0003);
    repeat (40) @(posedge mclk);
    chk(period, 16'h0006);
    // half a source period of trim
    retune(16'h8000, 16'h9200);
    repeat (40) @(posedge mclk);
    chk(period, 16'h0007);
    rd(2'h2, rd_val);
    chk(rd_val, 16'h8000);
    // source one at a quarter rate
    retune(16'h0000, 16'h9201);
    repeat (80) @(posedge mclk);
    chk(period, 16'h0018);
    // pin output enable off, generator keeps running
    wr(2'h0, 16'h8001);
    repeat (4) @(posedge mclk);
    chk({15'h0000, pin_oe}, 16'h0000);
    rd(2'h0, rd_val);
    chk(rd_val, 16'h8101);
    // sleep with a source that stops in sleep
    wr(2'h0, 16'h9801);
    @(posedge mclk) sleep_mode <= 1'b1;
    repeat (80) @(posedge mclk);
    #1 e0 = edges;
    repeat (80) @(posedge mclk);
    chk(edges, e0);
    @(posedge mclk) src_runs_in_sleep <= 16'h0002;
    repeat (80) @(posedge mclk);
    chk({15'h0000, edges > e0}, 16'h0001);
    wr(2'h0, 16'h9001);
    repeat (80) @(posedge mclk);
    #1 e0 = edges;
    repeat (80) @(posedge mclk);
    chk(edges, e0);
    @(posedge mclk) sleep_mode <= 1'b0;
    // fixed half clock
    @(posedge mclk) half_osc_allowed <= 1'b1;
    repeat (6) @(posedge mclk);
    #1 e0 = {15'h0000, half_out};
    @(posedge mclk);
    #1 chk({15'h0000, half_out}, {15'h0000, ~e0[0]});
    @(posedge mclk) half_osc_allowed <= 1'b0;
    repeat (6) @(posedge mclk);
    chk({15'h0000, half_out}, 16'h0000);
    wr(2'h0, 16'h0000);
    poll(16'h0100, 16'h0000);
    // zero divider: source one passes straight through, 1:1
    wr(2'h1, 16'h0000);
    retune(16'h0000, 16'h9201);
    repeat (40) @(posedge mclk);
    #1 chk(period, 16'h0004);
    // reset in mid-run clears everything again
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(2'h0, rd_val);
    chk(rd_val, 16'h0000);
    chk({13'h0000, pin_oe, pin, active}, 16'h0000);
    wrap_up;
  end

  // watchdog, well beyond the expected run length
  initial
  begin
    #100000;
    miscompares = miscompares + 1;
    wrap_up;
  end
endmodule // tb_top
